// ===== logic/csp_defines.svh
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH
// device register offsets
`define CSP_REG_FMT     8'h09
`define CSP_REG_OFFS    8'h0a
`define CSP_REG_OVF     8'h0b
`define CSP_REG_FILT    8'h0c
// device field positions and reset values
`define CSP_FMT_RATE    3
`define CSP_FMT_DRSYNC  2
`define CSP_FMT_ARSYNC  1
`define CSP_FMT_MUTE    0
`define CSP_FMT_RST     8'h00
`define CSP_OFFS_RST    8'h00
`define CSP_PLLR_RST    4'h1
`define CSP_FILT_RST    8'h00
`define CSP_HALF_RST    9'h010
// host register offsets (byte addresses) and fields
`define CSP_H_CTRL      8'h00
`define CSP_H_OFFS      8'h04
`define CSP_H_TXL       8'h08
`define CSP_H_TXR       8'h0c
`define CSP_H_RXL       8'h10
`define CSP_H_RXR       8'h14
`define CSP_H_STAT      8'h18
`define CSP_H_MASK      8'h1c
`define CSP_H_CTRL_RST  7'h00
// offset limits per format and frame mode
`define CSP_OFF_MAX_CONT     8'd17
`define CSP_OFF_MAX_CONT_DSP 8'd16
`define CSP_OFF_MAX_256      8'd242
`define CSP_OFF_MAX_256_DSP  8'd241
// timing
`define CSP_CORE_MHZ    200
`define CSP_MUTE_NS     2000
`define CSP_MUTE_CYC    ((`CSP_MUTE_NS * `CSP_CORE_MHZ + 999) / 1000)
`define CSP_BCLK_HALF   16
`endif

// ===== logic/csp_pkg.sv
package csp_pkg;
	// frame format codes in field order 00..11
	typedef enum logic [1:0] {CSP_I2S, CSP_DSP, CSP_RJ, CSP_LJ} csp_fmt_t;

	typedef struct packed {
		logic       act;
		logic       right;
		logic [4:0] idx;
	} csp_slot_t;

	function automatic logic [9:0] csp_wl_bits(input logic [1:0] code);
		case (code)
			2'b00: return 10'd16;
			2'b01: return 10'd20;
			2'b10: return 10'd24;
			default: return 10'd32;
		endcase
	endfunction

	// which channel and bit a frame position carries
	function automatic csp_slot_t csp_slot(input csp_fmt_t fmt, input logic [1:0] wlc,
		input logic [7:0] off, input logic [8:0] half, input logic [8:0] p,
		input logic [8:0] flen);
		logic [9:0] wl;
		logic [9:0] base;
		logic [9:0] rbase;
		logic [9:0] pp;
		csp_slot_t  s;
		wl = csp_wl_bits(wlc);
		pp = {1'b0, p};
		base = {2'b00, off} + ((fmt == CSP_I2S) ? 10'h001 : 10'h000);
		if (fmt == CSP_RJ) base = base + {1'b0, half} - wl;
		rbase = base + ((fmt == CSP_DSP) ? wl : {1'b0, half});
		s = '0;
		// a slot running past the frame end goes on at the next frame's start
		for (int k = 0; k < 2; k++) begin
			if (!s.act && pp >= base && pp < base + wl) begin
				s.act = 1'b1;
				s.idx = 5'(wl - 10'h001 - (pp - base));
			end else if (!s.act && pp >= rbase && pp < rbase + wl) begin
				s.act = 1'b1;
				s.right = 1'b1;
				s.idx = 5'(wl - 10'h001 - (pp - rbase));
			end
			pp = pp + {1'b0, flen};
		end
		return s;
	endfunction

	// word clock level a master drives at a frame position
	function automatic logic csp_wclk_lvl(input csp_fmt_t fmt, input logic [8:0] p,
		input logic [8:0] half);
		if (fmt == CSP_DSP) return p == 9'h000;
		if (fmt == CSP_I2S) return p >= half;
		return p < half;
	endfunction

	// frame start: falling word clock for i2s, rising otherwise
	function automatic logic csp_is_start(input csp_fmt_t fmt, input logic prv,
		input logic cur);
		return (fmt == CSP_I2S) ? (prv && !cur) : (!prv && cur);
	endfunction

	// mask for a right-aligned word of the given length
	function automatic logic [31:0] csp_mask(input logic [1:0] wlc);
		return 32'hffffffff >> (6'd32 - 6'(csp_wl_bits(wlc)));
	endfunction
endpackage

// ===== logic/csp_link_if.sv
`timescale 1ns/1ps
interface csp_link_if;
	logic dev_bclk_o;
	logic dev_bclk_oe;
	logic dev_wclk_o;
	logic dev_wclk_oe;
	logic host_bclk_o;
	logic host_bclk_oe;
	logic host_wclk_o;
	logic host_wclk_oe;
	logic bclk;
	logic wclk;
	logic dout;
	logic din;

	// clock owner: whichever end enables drives the wire, the device if both do
	assign bclk = dev_bclk_oe ? dev_bclk_o : (host_bclk_oe ? host_bclk_o : 1'b0);
	assign wclk = dev_wclk_oe ? dev_wclk_o : (host_wclk_oe ? host_wclk_o : 1'b0);

	modport dev (output dev_bclk_o, dev_bclk_oe, dev_wclk_o, dev_wclk_oe, dout,
		input bclk, wclk, din);
	modport host (output host_bclk_o, host_bclk_oe, host_wclk_o, host_wclk_oe, din,
		input bclk, wclk, dout);
endinterface

// ===== logic/csp_dev.sv
// Register access over a simple address, write and read strobe port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - format code selects i2s, dsp, rj, lj
// - word length code gives 16/20/24/32 bits
// - rate bit ignored unless device drives bclk
// - rate bit set gives 256 bclk per frame
// - dac resync on group delay drift
// - adc resync on group delay drift
// - mute bit soft-mutes channel during resync
// - offset field delays first data bit
// - dsp offset counts from rising word clock
// - continuous mode offset max 17, dsp 16; this device stores any 8-bit offset unchecked
// - 256-clock mode offset max 242, dsp 241; this device stores any 8-bit offset unchecked
// - four sticky overflow flags in all
// - reading overflow flags clears them
// - pll r code 0 means 16, reset 1
// - two-bit high-pass corner per adc channel
// - per dac effects filter enable bits
// - per dac de-emphasis enable bits
// - direction bits choose who drives clocks
`include "csp_defines.svh"
module csp_dev import csp_pkg::*; #(
	parameter int BCLK_HALF = `CSP_BCLK_HALF,
	parameter int MUTE_CYC  = `CSP_MUTE_CYC
) (
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        BCLK_DRIVE,
	input  wire logic        WCLK_DRIVE,
	input  wire logic [3:0]  OVF_EVT,
	input  wire logic [1:0]  DRIFT,
	input  wire logic [31:0] TX_LEFT,
	input  wire logic [31:0] TX_RIGHT,
	output logic             TX_TAKE,
	output logic      [31:0] RX_LEFT,
	output logic      [31:0] RX_RIGHT,
	output logic             RX_VALID,
	output logic      [4:0]  PLL_R_DIV,
	output logic      [3:0]  ADC_HPF,
	output logic      [1:0]  DAC_FX_EN,
	output logic      [1:0]  DAC_DEEMPH_EN,
	output logic      [1:0]  RESYNC,
	output logic      [1:0]  SOFT_MUTE,
	csp_link_if.dev          LINK
);
	if (BCLK_HALF < 2 || BCLK_HALF > 255) begin : g_chk_half
		$error("BCLK_HALF must lie in 2..255");
	end
	if (MUTE_CYC < 1 || MUTE_CYC > 65535) begin : g_chk_mute
		$error("MUTE_CYC must lie in 1..65535");
	end

	logic [7:0]  fmt_r;
	logic [7:0]  offs_r;
	logic [3:0]  pllr_r;
	logic [7:0]  filt_r;
	logic [3:0]  flags_r;
	logic [3:0]  flags_clr;
	logic [2:0]  bclk_q;
	logic [1:0]  wclk_q;
	logic [1:0]  din_q;
	logic [7:0]  div_r;
	logic        div_tick;
	logic        bclk_o_r;
	logic        bclk_oe_r;
	logic        wclk_o_r;
	logic        wclk_oe_r;
	logic        rise;
	logic        fall;
	logic [8:0]  flen;
	logic [8:0]  gen_r;
	logic [8:0]  gen_nxt;
	logic        wclk_in;
	logic        wclk_p_r;
	logic        start;
	logic [8:0]  pos_r;
	logic [8:0]  pos_n;
	logic [8:0]  nxt;
	logic [8:0]  flen_seen_r;
	logic [8:0]  half_r;
	logic [31:0] rx_sh_r;
	logic [31:0] rx_word;
	logic [31:0] txl_r;
	logic [31:0] txr_r;
	logic        dout_r;
	csp_fmt_t    fmt;
	csp_slot_t   rx_s;
	csp_slot_t   tx_s;

	assign fmt = csp_fmt_t'(fmt_r[7:6]);

	// register writes
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fmt_r <= `CSP_FMT_RST;
			offs_r <= `CSP_OFFS_RST;
			pllr_r <= `CSP_PLLR_RST;
			filt_r <= `CSP_FILT_RST;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`CSP_REG_FMT: fmt_r <= REG_WDATA;
				`CSP_REG_OFFS: offs_r <= REG_WDATA;
				`CSP_REG_OVF: pllr_r <= REG_WDATA[3:0];
				`CSP_REG_FILT: filt_r <= REG_WDATA;
				default: ;
			endcase
		end
	end

	assign flags_clr = (REG_RD && REG_ADDR == `CSP_REG_OVF) ? flags_r : 4'h0;

	// sticky flags; new event wins over clear
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			flags_r <= 4'h0;
		end else begin
			flags_r <= (flags_r & ~flags_clr) | OVF_EVT;
		end
	end

	// register reads, data one cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`CSP_REG_FMT: REG_RDATA <= fmt_r;
				`CSP_REG_OFFS: REG_RDATA <= offs_r;
				`CSP_REG_OVF: REG_RDATA <= {flags_r, pllr_r};
				`CSP_REG_FILT: REG_RDATA <= filt_r;
				default: REG_RDATA <= 8'h00;
			endcase
		end
	end

	// decoded filter and pll settings
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PLL_R_DIV <= 5'h01;
			ADC_HPF <= 4'h0;
			DAC_FX_EN <= 2'h0;
			DAC_DEEMPH_EN <= 2'h0;
		end else begin
			PLL_R_DIV <= (pllr_r == 4'h0) ? 5'h10 : {1'b0, pllr_r};
			// left corner code high, right low
			ADC_HPF <= filt_r[7:4];
			DAC_FX_EN <= {filt_r[3], filt_r[1]};
			DAC_DEEMPH_EN <= {filt_r[2], filt_r[0]};
		end
	end

	// resync and soft mute, index 0 dac, 1 adc
	for (genvar i = 0; i < 2; i++) begin : g_rsync
		logic        drift_p_r;
		logic [15:0] mute_cnt_r;
		logic        hit;
		assign hit = DRIFT[i] && !drift_p_r && fmt_r[`CSP_FMT_DRSYNC - i];
		always_ff @(posedge CORE_CLK or negedge ARST_N) begin
			if (!ARST_N) begin
				drift_p_r <= 1'b0;
				mute_cnt_r <= 16'h0000;
				RESYNC[i] <= 1'b0;
				SOFT_MUTE[i] <= 1'b0;
			end else begin
				drift_p_r <= DRIFT[i];
				RESYNC[i] <= hit;
				if (hit && fmt_r[`CSP_FMT_MUTE]) begin
					mute_cnt_r <= 16'(MUTE_CYC);
				end else if (mute_cnt_r != 16'h0000) begin
					mute_cnt_r <= mute_cnt_r - 16'h0001;
				end
				SOFT_MUTE[i] <= (hit && fmt_r[`CSP_FMT_MUTE]) || mute_cnt_r > 16'h0001;
			end
		end
	end

	// link pins pass two flops; bclk gets a third for edges
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bclk_q <= 3'h0;
			wclk_q <= 2'h0;
			din_q <= 2'h0;
		end else begin
			bclk_q <= {bclk_q[1:0], LINK.bclk};
			wclk_q <= {wclk_q[0], LINK.wclk};
			din_q <= {din_q[0], LINK.din};
		end
	end

	// bit clock divider while driving
	assign div_tick = bclk_oe_r && div_r == 8'(BCLK_HALF - 1);
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_r <= 8'h00;
			bclk_o_r <= 1'b0;
			bclk_oe_r <= 1'b0;
			wclk_oe_r <= 1'b0;
		end else begin
			// direction inputs pick the clock driver
			bclk_oe_r <= BCLK_DRIVE;
			wclk_oe_r <= WCLK_DRIVE;
			div_r <= (div_tick || !bclk_oe_r) ? 8'h00 : div_r + 8'h01;
			bclk_o_r <= bclk_oe_r ? bclk_o_r ^ div_tick : 1'b0;
		end
	end

	assign rise = bclk_oe_r ? (div_tick && !bclk_o_r) : (bclk_q[1] && !bclk_q[2]);
	assign fall = bclk_oe_r ? (div_tick && bclk_o_r) : (!bclk_q[1] && bclk_q[2]);

	// 256 bit clocks only when driving bclk
	assign flen = (bclk_oe_r && fmt_r[`CSP_FMT_RATE]) ? 9'h100
		: 9'(csp_wl_bits(fmt_r[5:4]) << 1);
	assign gen_nxt = (gen_r + 9'h001 >= flen) ? 9'h000 : gen_r + 9'h001;

	// word clock generator, changes on bclk falling
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gen_r <= 9'h000;
			wclk_o_r <= 1'b0;
		end else if (fall && wclk_oe_r) begin
			gen_r <= gen_nxt;
			wclk_o_r <= csp_wclk_lvl(fmt, gen_nxt, {1'b0, flen[8:1]});
		end
	end

	assign wclk_in = wclk_oe_r ? wclk_o_r : wclk_q[1];
	// dsp frame starts on rising word clock
	assign start = csp_is_start(fmt, wclk_p_r, wclk_in);
	assign pos_n = start ? 9'h000 : pos_r + 9'h001;
	assign nxt = (pos_r + 9'h001 == flen_seen_r) ? 9'h000 : pos_r + 9'h001;
	// slot position from format, length, offset
	assign rx_s = csp_slot(fmt, fmt_r[5:4], offs_r, half_r, pos_n, flen_seen_r);
	assign tx_s = csp_slot(fmt, fmt_r[5:4], offs_r, half_r, nxt, flen_seen_r);
	assign rx_word = {rx_sh_r[30:0], din_q[1]} & csp_mask(fmt_r[5:4]);

	// frame tracking and receive on bclk rising
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wclk_p_r <= 1'b0;
			pos_r <= 9'h000;
			flen_seen_r <= 9'h000;
			half_r <= `CSP_HALF_RST;
			rx_sh_r <= 32'h00000000;
			RX_LEFT <= 32'h00000000;
			RX_RIGHT <= 32'h00000000;
			RX_VALID <= 1'b0;
		end else begin
			RX_VALID <= 1'b0;
			if (rise) begin
				wclk_p_r <= wclk_in;
				pos_r <= pos_n;
				if (start) flen_seen_r <= pos_r + 9'h001;
				if (wclk_p_r != wclk_in && !start) half_r <= pos_n;
				if (rx_s.act) rx_sh_r <= {rx_sh_r[30:0], din_q[1]};
				if (rx_s.act && rx_s.idx == 5'h00 && !rx_s.right) RX_LEFT <= rx_word;
				if (rx_s.act && rx_s.idx == 5'h00 && rx_s.right) begin
					RX_RIGHT <= rx_word;
					RX_VALID <= 1'b1;
				end
			end
		end
	end

	// transmit on bclk falling, reload after right word
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dout_r <= 1'b0;
			txl_r <= 32'h00000000;
			txr_r <= 32'h00000000;
			TX_TAKE <= 1'b0;
		end else begin
			TX_TAKE <= 1'b0;
			if (fall) begin
				dout_r <= tx_s.act && (tx_s.right ? txr_r[tx_s.idx] : txl_r[tx_s.idx]);
				if (tx_s.act && tx_s.right && tx_s.idx == 5'h00) begin
					txl_r <= TX_LEFT;
					txr_r <= TX_RIGHT;
					TX_TAKE <= 1'b1;
				end
			end
		end
	end

	assign LINK.dev_bclk_o = bclk_o_r;
	assign LINK.dev_bclk_oe = bclk_oe_r;
	assign LINK.dev_wclk_o = wclk_o_r;
	assign LINK.dev_wclk_oe = wclk_oe_r;
	assign LINK.dout = dout_r;
endmodule

// ===== logic/csp_host.sv
`timescale 1ns/1ps
`include "csp_defines.svh"
module csp_host import csp_pkg::*; #(
	parameter int BCLK_HALF = `CSP_BCLK_HALF
) (
	input  wire logic        CORE_CLK,
	input  wire logic        ARST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             IRQ,
	csp_link_if.host         LINK
);
	if (BCLK_HALF < 2 || BCLK_HALF > 255) begin : g_chk_half
		$error("BCLK_HALF must lie in 2..255");
	end

	logic [6:0]  ctrl_r;
	logic [7:0]  offs_r;
	logic [7:0]  off_max;
	logic [31:0] txl_r;
	logic [31:0] txr_r;
	logic [31:0] rxl_r;
	logic [31:0] rxr_r;
	logic [1:0]  stat_r;
	logic [1:0]  mask_r;
	logic [1:0]  evt;
	logic        wr_acc;
	logic [2:0]  bclk_q;
	logic [1:0]  wclk_q;
	logic [1:0]  dout_q;
	logic [7:0]  div_r;
	logic        div_tick;
	logic        bclk_o_r;
	logic        wclk_o_r;
	logic        rise;
	logic        fall;
	logic [8:0]  flen;
	logic [8:0]  gen_r;
	logic [8:0]  gen_nxt;
	logic        wclk_in;
	logic        wclk_p_r;
	logic        start;
	logic [8:0]  pos_r;
	logic [8:0]  pos_n;
	logic [8:0]  nxt;
	logic [8:0]  flen_seen_r;
	logic [8:0]  half_r;
	logic [31:0] sh_r;
	logic [31:0] rx_word;
	logic [31:0] tl_r;
	logic [31:0] tr_r;
	logic        din_r;
	csp_fmt_t    fmt;
	csp_slot_t   rx_s;
	csp_slot_t   tx_s;

	// ctrl: 0 drive bclk, 1 drive wclk, 3:2 format, 5:4 length, 6 256-clock frames
	assign fmt = csp_fmt_t'(ctrl_r[3:2]);
	assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
	// largest offset for format and frame mode
	assign off_max = ctrl_r[6] ? ((fmt == CSP_DSP) ? `CSP_OFF_MAX_256_DSP : `CSP_OFF_MAX_256)
		: ((fmt == CSP_DSP) ? `CSP_OFF_MAX_CONT_DSP : `CSP_OFF_MAX_CONT);

	// apb: ready in every access cycle, read data set up in the setup cycle
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= PSEL && !PENABLE;
			PSLVERR <= PSEL && !PENABLE && PADDR > `CSP_H_MASK;
			if (PSEL && !PENABLE) begin
				case (PADDR)
					`CSP_H_CTRL: PRDATA <= {25'h0, ctrl_r};
					`CSP_H_OFFS: PRDATA <= {24'h0, offs_r};
					`CSP_H_TXL: PRDATA <= txl_r;
					`CSP_H_TXR: PRDATA <= txr_r;
					`CSP_H_RXL: PRDATA <= rxl_r;
					`CSP_H_RXR: PRDATA <= rxr_r;
					`CSP_H_STAT: PRDATA <= {30'h0, stat_r};
					`CSP_H_MASK: PRDATA <= {30'h0, mask_r};
					default: PRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	// apb writes; offset saturates at the legal limit
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_r <= `CSP_H_CTRL_RST;
			offs_r <= `CSP_OFFS_RST;
			txl_r <= 32'h00000000;
			txr_r <= 32'h00000000;
			mask_r <= 2'h0;
		end else if (wr_acc) begin
			case (PADDR)
				`CSP_H_CTRL: ctrl_r <= PWDATA[6:0];
				`CSP_H_OFFS: offs_r <= (PWDATA[7:0] > off_max) ? off_max : PWDATA[7:0];
				`CSP_H_TXL: txl_r <= PWDATA;
				`CSP_H_TXR: txr_r <= PWDATA;
				`CSP_H_MASK: mask_r <= PWDATA[1:0];
				default: ;
			endcase
		end
	end

	// sticky events, write one clears, a new event wins
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			stat_r <= 2'h0;
			IRQ <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~((wr_acc && PADDR == `CSP_H_STAT) ? PWDATA[1:0] : 2'h0)) | evt;
			IRQ <= |(stat_r & mask_r);
		end
	end

	// link pins pass two flops
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bclk_q <= 3'h0;
			wclk_q <= 2'h0;
			dout_q <= 2'h0;
		end else begin
			bclk_q <= {bclk_q[1:0], LINK.bclk};
			wclk_q <= {wclk_q[0], LINK.wclk};
			dout_q <= {dout_q[0], LINK.dout};
		end
	end

	// host drives the clocks it owns
	assign div_tick = ctrl_r[0] && div_r == 8'(BCLK_HALF - 1);
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_r <= 8'h00;
			bclk_o_r <= 1'b0;
		end else begin
			div_r <= (div_tick || !ctrl_r[0]) ? 8'h00 : div_r + 8'h01;
			bclk_o_r <= ctrl_r[0] ? bclk_o_r ^ div_tick : 1'b0;
		end
	end

	assign rise = ctrl_r[0] ? (div_tick && !bclk_o_r) : (bclk_q[1] && !bclk_q[2]);
	assign fall = ctrl_r[0] ? (div_tick && bclk_o_r) : (!bclk_q[1] && bclk_q[2]);
	// frame length when the host is bclk master
	assign flen = (ctrl_r[0] && ctrl_r[6]) ? 9'h100 : 9'(csp_wl_bits(ctrl_r[5:4]) << 1);
	assign gen_nxt = (gen_r + 9'h001 >= flen) ? 9'h000 : gen_r + 9'h001;

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gen_r <= 9'h000;
			wclk_o_r <= 1'b0;
		end else if (fall && ctrl_r[1]) begin
			gen_r <= gen_nxt;
			wclk_o_r <= csp_wclk_lvl(fmt, gen_nxt, {1'b0, flen[8:1]});
		end
	end

	assign wclk_in = ctrl_r[1] ? wclk_o_r : wclk_q[1];
	assign start = csp_is_start(fmt, wclk_p_r, wclk_in);
	assign pos_n = start ? 9'h000 : pos_r + 9'h001;
	assign nxt = (pos_r + 9'h001 == flen_seen_r) ? 9'h000 : pos_r + 9'h001;
	assign rx_s = csp_slot(fmt, ctrl_r[5:4], offs_r, half_r, pos_n, flen_seen_r);
	assign tx_s = csp_slot(fmt, ctrl_r[5:4], offs_r, half_r, nxt, flen_seen_r);
	assign rx_word = {sh_r[30:0], dout_q[1]} & csp_mask(ctrl_r[5:4]);
	assign evt = {fall && tx_s.act && tx_s.right && tx_s.idx == 5'h00,
		rise && rx_s.act && rx_s.right && rx_s.idx == 5'h00};

	// receive from the device on bclk rising
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wclk_p_r <= 1'b0;
			pos_r <= 9'h000;
			flen_seen_r <= 9'h000;
			half_r <= `CSP_HALF_RST;
			sh_r <= 32'h00000000;
			rxl_r <= 32'h00000000;
			rxr_r <= 32'h00000000;
		end else if (rise) begin
			wclk_p_r <= wclk_in;
			pos_r <= pos_n;
			if (start) flen_seen_r <= pos_r + 9'h001;
			if (wclk_p_r != wclk_in && !start) half_r <= pos_n;
			if (rx_s.act) sh_r <= {sh_r[30:0], dout_q[1]};
			if (rx_s.act && rx_s.idx == 5'h00 && !rx_s.right) rxl_r <= rx_word;
			if (evt[0]) rxr_r <= rx_word;
		end
	end

	// transmit to the device on bclk falling
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			din_r <= 1'b0;
			tl_r <= 32'h00000000;
			tr_r <= 32'h00000000;
		end else if (fall) begin
			din_r <= tx_s.act && (tx_s.right ? tr_r[tx_s.idx] : tl_r[tx_s.idx]);
			if (evt[1]) begin
				tl_r <= txl_r;
				tr_r <= txr_r;
			end
		end
	end

	assign LINK.host_bclk_o = bclk_o_r;
	assign LINK.host_bclk_oe = ctrl_r[0];
	assign LINK.host_wclk_o = wclk_o_r;
	assign LINK.host_wclk_oe = ctrl_r[1];
	assign LINK.din = din_r;
endmodule

// ===== testbench/csp_assertions.sv
`timescale 1ns/1ps
module csp_assertions #(
	parameter int BCLK_HALF = 16
) (
	input wire logic        CORE_CLK,
	input wire logic        ARST_N,
	input wire logic        BCLK_DRIVE,
	input wire logic        WCLK_DRIVE,
	input wire logic [1:0]  DRIFT,
	input wire logic [1:0]  RESYNC,
	input wire logic [1:0]  SOFT_MUTE,
	input wire logic [4:0]  PLL_R_DIV,
	input wire logic        dev_bclk_o,
	input wire logic        dev_bclk_oe,
	input wire logic        dev_wclk_oe
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	logic       bprv_r;
	logic [7:0] hcnt_r;
	// cycles since the device bit clock last toggled
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			bprv_r <= 1'b0;
			hcnt_r <= 8'h00;
		end else begin
			bprv_r <= dev_bclk_o;
			hcnt_r <= (dev_bclk_o != bprv_r) ? 8'h01 : hcnt_r + 8'h01;
		end
	end
	sequence s_adc_mute;
		SOFT_MUTE[1] [*4] ##1 !SOFT_MUTE[1];
	endsequence
	property p_bclk_dir;
		1'b1 |=> dev_bclk_oe == $past(BCLK_DRIVE);
	endproperty
	property p_wclk_dir;
		1'b1 |=> dev_wclk_oe == $past(WCLK_DRIVE);
	endproperty
	property p_bclk_half;
		dev_bclk_oe && $past(dev_bclk_oe, 40) && dev_bclk_o != bprv_r |-> hcnt_r == 8'(BCLK_HALF);
	endproperty
	property p_dac_resync;
		RESYNC[0] |-> $past(DRIFT[0]) && !$past(DRIFT[0], 2) ##1 !RESYNC[0];
	endproperty
	property p_adc_resync;
		RESYNC[1] |-> $past(DRIFT[1]) && !$past(DRIFT[1], 2) ##1 !RESYNC[1];
	endproperty
	property p_adc_mute;
		$rose(SOFT_MUTE[1]) |-> s_adc_mute;
	endproperty
	property p_mute_cause;
		$rose(SOFT_MUTE[0]) |-> RESYNC[0];
	endproperty
	property p_pll_range;
		PLL_R_DIV inside {[5'd1:5'd16]};
	endproperty
	a_bclk_dir: assert property (p_bclk_dir) else $error("bclk enable wrong");
	a_wclk_dir: assert property (p_wclk_dir) else $error("wclk enable wrong");
	a_bclk_half: assert property (p_bclk_half) else $error("bclk half period");
	a_dac_resync: assert property (p_dac_resync) else $error("dac resync");
	a_adc_resync: assert property (p_adc_resync) else $error("adc resync");
	a_adc_mute: assert property (p_adc_mute) else $error("mute length");
	a_mute_cause: assert property (p_mute_cause) else $error("mute cause");
	a_pll_range: assert property (p_pll_range) else $error("pll r value");
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
	logic        CORE_CLK, ARST_N, REG_WR, REG_RD, BCLK_DRIVE, WCLK_DRIVE, TX_TAKE, RX_VALID;
	logic        PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, err;
	logic [1:0]  DRIFT, RESYNC, SOFT_MUTE, DAC_FX_EN, DAC_DEEMPH_EN, r, m;
	logic [3:0]  OVF_EVT, ADC_HPF;
	logic [4:0]  PLL_R_DIV;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, PADDR, q8;
	logic [31:0] TX_LEFT, TX_RIGHT, RX_LEFT, RX_RIGHT, PWDATA, PRDATA, q;
	int          fails, n_tests, cyc;
	int          wl[4] = '{16, 20, 24, 32};
	csp_link_if link();
	csp_dev #(.MUTE_CYC(4)) i_csp_dev (.*, .LINK(link));
	csp_host i_csp_host (.*, .LINK(link));
	csp_assertions i_csp_assertions (.*, .dev_bclk_o(link.dev_bclk_o),
		.dev_bclk_oe(link.dev_bclk_oe),
		.dev_wclk_oe(link.dev_wclk_oe));
	// 200 MHz core clock
	initial begin
		CORE_CLK = 1'b0;
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end
	// hang guard
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fails++;
			report_and_stop();
		end
	end
	task report_and_stop();
		$display("%0d checks, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// device register access, overflow events ride along
	task dev(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] ov);
		@(posedge CORE_CLK);
		{REG_WR, REG_RD, REG_ADDR, REG_WDATA, OVF_EVT} <= {w, !w, a, d, ov};
		@(posedge CORE_CLK);
		{REG_WR, REG_RD, OVF_EVT} <= 6'h00;
		@(negedge CORE_CLK);
		q8 = REG_RDATA;
		@(negedge CORE_CLK);
	endtask
	// apb transfer: setup, access until ready, release
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CORE_CLK);
		end while (!PREADY);
		q = PRDATA;
		err = PSLVERR;
		{PSEL, PENABLE} <= 2'b00;
	endtask
	// one link setting, both ends, frame length and data both ways
	task run_link(input logic [1:0] f, l, input logic [7:0] o, input logic hm, dr, hr);
		int c, t;
		logic [31:0] mk;
		mk = 32'hffffffff >> (32 - wl[l]);
		dev(1'b1, 8'h09, {f, l, dr, 3'b000}, 4'h0);
		dev(1'b1, 8'h0a, o, 4'h0);
		apb(1'b1, 8'h00, {25'h0, hr, l, f, hm, hm});
		apb(1'b1, 8'h04, {24'h0, o});
		@(posedge CORE_CLK);
		{BCLK_DRIVE, WCLK_DRIVE} <= {!hm, !hm};
		repeat (3) begin
			@(negedge CORE_CLK);
			while (!RX_VALID) @(negedge CORE_CLK);
		end
		c = 0;
		t = 0;
		do begin
			@(negedge CORE_CLK);
			c++;
			t += TX_TAKE;
		end while (!RX_VALID);
		chk(c, ((hm ? hr : dr) ? 256 : 2 * wl[l]) * 32);
		chk(t, 1);
		chk(RX_LEFT, 32'h8c3a5e71 & mk);
		chk(RX_RIGHT, 32'h17f0c2b9 & mk);
		apb(1'b0, 8'h10, 32'h0);
		chk(q, TX_LEFT & mk);
		apb(1'b0, 8'h14, 32'h0);
		chk(q, TX_RIGHT & mk);
		$display("link test fmt %0d len %0d done", f, l);
	endtask
	initial begin
		logic [7:0] ra[5] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h20};
		logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
		logic [7:0] fv[2] = '{8'he4, 8'h1b};
		logic [7:0] ov[2] = '{8'he2, 8'h1d};
		logic [7:0] en[3] = '{8'h07, 8'h06, 8'h00};
		logic [1:0] er[3] = '{2'h3, 2'h3, 2'h0};
		logic [1:0] em[3] = '{2'h3, 2'h0, 2'h0};
		{ARST_N, REG_WR, REG_RD, BCLK_DRIVE, WCLK_DRIVE, PSEL, PENABLE, PWRITE} = 8'h00;
		{REG_ADDR, REG_WDATA, PADDR, PWDATA, OVF_EVT, DRIFT} = '0;
		TX_LEFT = 32'h5ad3c0f6;
		TX_RIGHT = 32'hc1e4a97d;
		repeat (20) @(posedge CORE_CLK);
		ARST_N <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			dev(1'b0, ra[i], 8'h00, 4'h0);
			chk(q8, rv[i]);
		end
		chk(PLL_R_DIV, 5'd1);
		$display("reset test done");
		for (int i = 0; i < 2; i++) begin
			dev(1'b1, 8'h0c, fv[i], 4'h0);
			chk({ADC_HPF, DAC_FX_EN, DAC_DEEMPH_EN}, ov[i]);
			dev(1'b0, 8'h0c, 8'h00, 4'h0);
			chk(q8, fv[i]);
		end
		dev(1'b1, 8'h0b, 8'h00, 4'h0);
		chk(PLL_R_DIV, 5'd16);
		dev(1'b1, 8'h0b, 8'hf5, 4'h0);
		chk(PLL_R_DIV, 5'd5);
		dev(1'b1, 8'h20, 8'hff, 4'b1010);
		dev(1'b0, 8'h0b, 8'h00, 4'b1000);
		chk(q8, 8'ha5);
		dev(1'b0, 8'h0b, 8'h00, 4'b0001);
		chk(q8, 8'h85);
		dev(1'b0, 8'h0b, 8'h00, 4'h0);
		chk(q8, 8'h15);
		dev(1'b0, 8'h0b, 8'h00, 4'h0);
		chk(q8, 8'h05);
		$display("register test done");
		for (int i = 0; i < 3; i++) begin
			dev(1'b1, 8'h09, en[i], 4'h0);
			@(posedge CORE_CLK);
			DRIFT <= 2'b11;
			{r, m} = 4'h0;
			repeat (8) begin
				@(negedge CORE_CLK);
				r = r | RESYNC;
				m = m | SOFT_MUTE;
			end
			chk(r, er[i]);
			chk(m, em[i]);
			@(posedge CORE_CLK);
			DRIFT <= 2'b00;
		end
		$display("resync test done");
		apb(1'b1, 8'h04, 32'd200);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'd17);
		apb(1'b1, 8'h00, 32'h44);
		apb(1'b1, 8'h04, 32'hff);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'd241);
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1);
		chk(q, 32'h0);
		apb(1'b1, 8'h08, 32'h8c3a5e71);
		apb(1'b1, 8'h0c, 32'h17f0c2b9);
		run_link(2'd0, 2'd0, 8'd0, 1'b1, 1'b1, 1'b0);
		run_link(2'd1, 2'd1, 8'd4, 1'b1, 1'b0, 1'b0);
		run_link(2'd2, 2'd2, 8'd2, 1'b1, 1'b0, 1'b0);
		run_link(2'd3, 2'd3, 8'd1, 1'b0, 1'b0, 1'b0);
		run_link(2'd1, 2'd3, 8'd5, 1'b0, 1'b1, 1'b0);
		apb(1'b1, 8'h00, 32'h0);
		@(posedge CORE_CLK);
		{BCLK_DRIVE, WCLK_DRIVE} <= 2'b00;
		repeat (300) @(posedge CORE_CLK);
		apb(1'b0, 8'h18, 32'h0);
		chk(q & 32'h1, 32'h1);
		chk(IRQ, 1'b0);
		apb(1'b1, 8'h1c, 32'h1);
		repeat (2) @(negedge CORE_CLK);
		chk(IRQ, 1'b1);
		apb(1'b1, 8'h18, 32'h3);
		repeat (2) @(negedge CORE_CLK);
		chk(IRQ, 1'b0);
		apb(1'b0, 8'h18, 32'h0);
		chk(q, 32'h0);
		$display("interrupt test done");
		report_and_stop();
	end
endmodule
